/* design/mode_config_defs.vh */
// Constants of the reset mode and feature configuration block.
// Assumes a single clk domain and a plain strobe register port.
`ifndef MODE_CONFIG_DEFS_VH
`define MODE_CONFIG_DEFS_VH

// Register offsets
`define CFG_OFFSET 8'h00
`define STAT_OFFSET 8'h04

// Configuration word fields
`define CFG_LOCK_BIT 31
`define CFG_SLOW_BIT 30
`define CFG_REFILL_BIT 29
`define CFG_FPINT_HI 28
`define CFG_FPINT_LO 26
`define CFG_HALT_BIT 25
`define CFG_RF_BIT 24
`define CFG_ALT_BIT 23

// Float interrupt pin reset value and largest accepted value
`define FPINT_RESET 3'h3
`define FPINT_MAX 3'h5

// Strap pin positions
`define STRAP_COHERENT 5
`define STRAP_UNITY 4
`define STRAP_HALF_BUS 3
`define STRAP_REFILL 2
`define STRAP_TRISTATE 1
`define STRAP_BYTE_ORDER 0

// Status word fields
`define STAT_HALTED_BIT 8
`define STAT_TAKEN_BIT 9

// Timing counts in clk cycles
`define RF_DIVIDE 6'h10
`define GAP_NORMAL 3'h1
`define GAP_SLOW 3'h3

// Cache split in kB
`define ICACHE_KB_RESET 5'h10
`define DCACHE_KB_RESET 5'h04
`define CACHE_KB_ALT 5'h08

`endif

/* design/rate_divider.v */
// Tick divider: emits one tick for every period-th step pulse.
// Assumes period is at least one and changes only between ticks.
`include "mode_config_defs.vh"

module rate_divider (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control
  input wire step,
  input wire [5:0] period,
  // Result
  output wire tick
);

reg [5:0] count_ff;
reg [5:0] nxt_count;

assign tick = step && (count_ff >= period - 6'h01);

always @* begin
  nxt_count = count_ff;
  if (tick) begin
    nxt_count = 6'h00;
  end else if (step) begin
    nxt_count = count_ff + 6'h01;
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    count_ff <= 6'h00;
  end else begin
    count_ff <= nxt_count;
  end
end

endmodule

/* design/mode_config.v */
// Reset mode capture, configuration word, clock ticks, halt, interrupt routing,
// turnaround gap, cache layout, parity and coherency invalidation.
// Assumes board logic holds the interrupt pins steady while reset_n is low
// and clk runs during reset.
`include "mode_config_defs.vh"

module mode_config (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // Interrupt pins, active low, also mode straps during reset
  input wire [5:0] int_pins_n,
  // Float unit interrupt request, active high
  input wire float_unit_irq,
  // Interrupts seen by the core, active high
  output reg [5:0] core_irq,
  // Clock ticks
  output wire exec_tick,
  output wire bus_tick,
  output reg exec_stall,
  // Bus turnaround
  input wire read_data_done,
  output wire cpu_drive_ok,
  // Mode outputs
  output reg coherent_dma_en,
  output reg unity_clock_en,
  output reg half_bus_en,
  output reg tristate_test,
  output reg big_endian,
  output reg [2:0] refill_words,
  output reg [4:0] icache_kb,
  output reg [4:0] dcache_kb,
  // Cache parity
  input wire [31:0] cache_data,
  input wire [19:0] cache_tag,
  output reg data_parity,
  output reg tag_parity,
  // Coherency
  input wire dma_write,
  input wire [31:0] dma_addr,
  output reg inval_valid,
  output reg [31:0] inval_addr
);

////////////////////////////////////////////////////////////////////////////////
// Functions

function parity32;
  input [31:0] value;
  begin
    parity32 = ^value;
  end
endfunction

function [5:0] one_hot6;
  input [2:0] index;
  begin
    one_hot6 = 6'h01 << index;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser, free running so it sees the levels during reset

reg [5:0] pin_meta_ff;
reg [5:0] pin_sync_ff;

always @(posedge clk) begin
  pin_meta_ff <= int_pins_n;
  pin_sync_ff <= pin_meta_ff;
end

////////////////////////////////////////////////////////////////////////////////
// Strap capture at the first edge after reset release

reg [5:0] strap_ff;
reg taken_ff;

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    strap_ff <= 6'h3f;
    taken_ff <= 1'b0;
  end else if (!taken_ff) begin
    strap_ff <= pin_sync_ff;
    taken_ff <= 1'b1;
  end
end

always @* begin
  coherent_dma_en = !strap_ff[`STRAP_COHERENT];
  unity_clock_en = !strap_ff[`STRAP_UNITY];
  half_bus_en = !strap_ff[`STRAP_HALF_BUS];
  tristate_test = strap_ff[`STRAP_TRISTATE];
  big_endian = strap_ff[`STRAP_BYTE_ORDER];
end

////////////////////////////////////////////////////////////////////////////////
// Configuration word

reg lock_ff;
reg slow_ff;
reg refill_ff;
reg [2:0] fpint_ff;
reg halt_ff;
reg rf_ff;
reg alt_ff;
reg nxt_lock;
reg nxt_slow;
reg nxt_refill;
reg [2:0] nxt_fpint;
reg nxt_halt;
reg nxt_rf;
reg nxt_alt;

wire cfg_write;
wire wake;

assign cfg_write = reg_write && (reg_addr == `CFG_OFFSET) && taken_ff && !lock_ff;

always @* begin
  nxt_lock = lock_ff;
  nxt_slow = slow_ff;
  nxt_refill = refill_ff;
  nxt_fpint = fpint_ff;
  nxt_halt = halt_ff;
  nxt_rf = rf_ff;
  nxt_alt = alt_ff;
  if (!taken_ff) begin
    nxt_refill = pin_sync_ff[`STRAP_REFILL];
    nxt_slow = !pin_sync_ff[`STRAP_HALF_BUS];
  end else begin
    if (wake) begin
      nxt_halt = 1'b0;
    end
    if (cfg_write) begin
      nxt_lock = reg_wdata[`CFG_LOCK_BIT];
      nxt_slow = reg_wdata[`CFG_SLOW_BIT];
      nxt_refill = reg_wdata[`CFG_REFILL_BIT];
      if (reg_wdata[`CFG_FPINT_HI:`CFG_FPINT_LO] <= `FPINT_MAX) begin
        nxt_fpint = reg_wdata[`CFG_FPINT_HI:`CFG_FPINT_LO];
      end
      nxt_halt = reg_wdata[`CFG_HALT_BIT] || (halt_ff && !wake);
      nxt_rf = reg_wdata[`CFG_RF_BIT];
      nxt_alt = reg_wdata[`CFG_ALT_BIT];
    end
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    lock_ff <= 1'b0;
    slow_ff <= 1'b0;
    refill_ff <= 1'b0;
    fpint_ff <= `FPINT_RESET;
    halt_ff <= 1'b0;
    rf_ff <= 1'b0;
    alt_ff <= 1'b0;
  end else begin
    lock_ff <= nxt_lock;
    slow_ff <= nxt_slow;
    refill_ff <= nxt_refill;
    fpint_ff <= nxt_fpint;
    halt_ff <= nxt_halt;
    rf_ff <= nxt_rf;
    alt_ff <= nxt_alt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt routing

reg [5:0] nxt_core_irq;
wire [5:0] fp_sel;

assign fp_sel = one_hot6(fpint_ff);
assign wake = |core_irq;

always @* begin
  // The pin that carries the float interrupt is ignored
  nxt_core_irq = ~pin_sync_ff & ~fp_sel;
  if (float_unit_irq) begin
    nxt_core_irq = nxt_core_irq | fp_sel;
  end
  if (!taken_ff) begin
    nxt_core_irq = 6'h00;
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    core_irq <= 6'h00;
  end else begin
    core_irq <= nxt_core_irq;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Execution and bus ticks

wire [5:0] exec_period;
wire [5:0] bus_period;
wire [5:0] base_period;

assign base_period = unity_clock_en ? 6'h01 : 6'h02;
assign exec_period = rf_ff ? (base_period * `RF_DIVIDE) : base_period;
assign bus_period = half_bus_en ? 6'h02 : 6'h01;

rate_divider exec_div (
  .clk(clk),
  .reset_n(reset_n),
  .step(taken_ff),
  .period(exec_period),
  .tick(exec_tick)
);

rate_divider bus_div (
  .clk(clk),
  .reset_n(reset_n),
  .step(exec_tick),
  .period(bus_period),
  .tick(bus_tick)
);

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    exec_stall <= 1'b0;
  end else begin
    exec_stall <= nxt_halt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Bus turnaround gap

reg [2:0] gap_ff;
reg [2:0] nxt_gap;

assign cpu_drive_ok = (gap_ff == 3'h0);

always @* begin
  nxt_gap = gap_ff;
  if (read_data_done) begin
    nxt_gap = slow_ff ? `GAP_SLOW : `GAP_NORMAL;
  end else if (gap_ff != 3'h0) begin
    nxt_gap = gap_ff - 3'h1;
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    gap_ff <= 3'h0;
  end else begin
    gap_ff <= nxt_gap;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Cache layout, refill size, parity and coherency

always @* begin
  refill_words = refill_ff ? 3'h4 : 3'h1;
  icache_kb = alt_ff ? `CACHE_KB_ALT : `ICACHE_KB_RESET;
  dcache_kb = alt_ff ? `CACHE_KB_ALT : `DCACHE_KB_RESET;
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    data_parity <= 1'b0;
    tag_parity <= 1'b0;
    inval_valid <= 1'b0;
    inval_addr <= 32'h0;
  end else begin
    data_parity <= parity32(cache_data);
    tag_parity <= parity32({12'h000, cache_tag});
    inval_valid <= dma_write && coherent_dma_en;
    if (dma_write && coherent_dma_en) begin
      inval_addr <= dma_addr;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port

reg [31:0] nxt_rdata;

always @* begin
  nxt_rdata = 32'h0;
  if (reg_read) begin
    case (reg_addr)
      `CFG_OFFSET: begin
        nxt_rdata[`CFG_LOCK_BIT] = lock_ff;
        nxt_rdata[`CFG_SLOW_BIT] = slow_ff;
        nxt_rdata[`CFG_REFILL_BIT] = refill_ff;
        nxt_rdata[`CFG_FPINT_HI:`CFG_FPINT_LO] = fpint_ff;
        nxt_rdata[`CFG_HALT_BIT] = halt_ff;
        nxt_rdata[`CFG_RF_BIT] = rf_ff;
        nxt_rdata[`CFG_ALT_BIT] = alt_ff;
      end
      `STAT_OFFSET: begin
        nxt_rdata[5:0] = strap_ff;
        nxt_rdata[`STAT_HALTED_BIT] = halt_ff;
        nxt_rdata[`STAT_TAKEN_BIT] = taken_ff;
      end
      default: begin
        nxt_rdata = 32'h0;
      end
    endcase
  end
end

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    reg_rdata <= 32'h0;
  end else begin
    reg_rdata <= nxt_rdata;
  end
end

endmodule

/* test/strap_driver.sv */
// Board reset logic model: drives mode straps on the interrupt pins.
// Assumes the bench gives strap and interrupt levels, all active low pins.
module strap_driver (
  // Control
  input wire logic reset_n,
  input wire logic [5:0] strap,
  input wire logic [5:0] irq_n,
  // Pins
  output logic [5:0] int_pins_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps while reset is low, interrupt levels after
  assign int_pins_n = reset_n ? irq_n : strap;
endmodule

/* test/mode_config_assertions.sv */
// Port checker for the mode configuration block.
// Assumes it is bound to mode_config, one clk domain.
module mode_config_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Watched ports
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [5:0] core_irq,
  input wire logic exec_tick,
  input wire logic bus_tick,
  input wire logic exec_stall,
  input wire logic read_data_done,
  input wire logic cpu_drive_ok,
  input wire logic coherent_dma_en,
  input wire logic unity_clock_en,
  input wire logic half_bus_en,
  input wire logic [4:0] icache_kb,
  input wire logic [4:0] dcache_kb,
  input wire logic dma_write,
  input wire logic [31:0] dma_addr,
  input wire logic inval_valid,
  input wire logic [31:0] inval_addr
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_INVAL_ON: assert property (
    dma_write && coherent_dma_en |=> inval_valid && inval_addr == $past(dma_addr))
    else $error("no invalidate");
  AST_INVAL_OFF: assert property (
    dma_write && !coherent_dma_en |=> !inval_valid) else $error("stray invalidate");
  AST_MODE_HOLD: assert property (
    $past(reset_n) && $past(reset_n, 2)
    |-> $stable({coherent_dma_en, unity_clock_en, half_bus_en})) else $error("mode moved");
  AST_GAP: assert property (
    read_data_done |=> !cpu_drive_ok) else $error("no turnaround gap");
  AST_BUS_SUB: assert property (
    bus_tick |-> exec_tick) else $error("bus tick alone");
  AST_BUS_FULL: assert property (
    !half_bus_en |-> bus_tick == exec_tick) else $error("bus rate wrong");
  AST_WAKE: assert property (
    exec_stall && |core_irq && !(reg_write && reg_addr == 8'h00 && reg_wdata[25])
    |=> !exec_stall) else $error("halt kept");
  AST_CACHE: assert property (
    {icache_kb, dcache_kb} == {5'h10, 5'h04} || {icache_kb, dcache_kb} == {5'h08, 5'h08})
    else $error("cache split");
  AST_CACHE_MOVE: assert property (
    !$stable({icache_kb, dcache_kb}) |-> $past(reg_write && reg_addr == 8'h00))
    else $error("cache split moved without a config write");
endmodule

bind mode_config mode_config_assertions chk (.clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_write, .core_irq, .exec_tick, .bus_tick, .exec_stall, .read_data_done,
  .cpu_drive_ok, .coherent_dma_en, .unity_clock_en, .half_bus_en, .icache_kb,
  .dcache_kb, .dma_write, .dma_addr, .inval_valid, .inval_addr);

/* test/mode_config_tb.sv */
// Bench for the mode configuration block: straps, register port, modes.
// Assumes the strap model on the pins and a 125 MHz clk.
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module mode_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0;
  logic float_unit_irq = 0, read_data_done = 0, dma_write = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, cache_data = '0, dma_addr = '0, inval_addr;
  logic [19:0] cache_tag = '0;
  logic [5:0] strap = 6'h3f, irq_n = 6'h3f, int_pins_n, core_irq;
  logic [2:0] refill_words;
  logic [4:0] icache_kb, dcache_kb;
  logic exec_tick, bus_tick, exec_stall, cpu_drive_ok, coherent_dma_en, unity_clock_en;
  logic half_bus_en, tristate_test, big_endian, data_parity, tag_parity, inval_valid;
  logic [4:0] modes;
  assign modes = {coherent_dma_en, unity_clock_en, half_bus_en, tristate_test, big_endian};
  int error_cnt = 0, samples_checked = 0, n;
  always #4 clk = ~clk;
  strap_driver board (.reset_n, .strap, .irq_n, .int_pins_n);
  mode_config dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .int_pins_n, .float_unit_irq, .core_irq, .exec_tick, .bus_tick,
    .exec_stall, .read_data_done, .cpu_drive_ok, .coherent_dma_en, .unity_clock_en,
    .half_bus_en, .tristate_test, .big_endian, .refill_words, .icache_kb, .dcache_kb,
    .cache_data, .cache_tag, .data_parity, .tag_parity, .dma_write, .dma_addr,
    .inval_valid, .inval_addr);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic boot(input logic [5:0] s);
    reset_n <= 1'b0;
    strap <= s;
    irq_n <= 6'h3f;
    cyc(6);
    reset_n <= 1'b1;
    cyc(2);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    reg_addr <= 8'h00;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    cyc(4);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask
  task automatic ticks(input int ee, input int eb);
    int ne, nb;
    ne = 0;
    nb = 0;
    cyc(32);
    repeat (32) begin
      @(posedge clk);
      #1 ne += exec_tick;
      nb += bus_tick;
    end
    `CHK("exec", ee, ne)
    `CHK("bus", eb, nb)
  endtask
  task automatic gap_dma(input int e, input logic v);
    int lo;
    lo = 0;
    @(posedge clk);
    read_data_done <= 1'b1;
    dma_write <= 1'b1;
    dma_addr <= 32'h0000_1230;
    @(posedge clk);
    read_data_done <= 1'b0;
    dma_write <= 1'b0;
    #1 `CHK("inval", v, inval_valid)
    repeat (6) begin
      lo += !cpu_drive_ok;
      @(posedge clk);
      #1;
    end
    `CHK("gap", e, lo)
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    boot(6'h3f);
    `CHK("modes", 5'h03, modes)
    `CHK("caches", {5'h10, 5'h04}, {icache_kb, dcache_kb})
    `CHK("refill", 3'h4, refill_words)
    rd(8'h00, 32'h2c00_0000);
    rd(8'h04, 32'h0000_023f);
    gap_dma(1, 1'b0);
    ticks(16, 16);
    @(posedge clk);
    irq_n <= 6'h00;
    cyc(5);
    #1 `CHK("masked", 6'h37, core_irq)
    `CHK("held", 5'h03, modes)
    $display("test compatible straps done");
    @(posedge clk);
    boot(6'h00);
    `CHK("modes", 5'h1c, modes)
    rd(8'h00, 32'h4c00_0000);
    rd(8'h04, 32'h0000_0200);
    gap_dma(3, 1'b1);
    ticks(32, 16);
    wr(32'h4100_0000);
    ticks(2, 1);
    $display("test enabled straps done");
    wr(32'h4000_0000);
    wr(32'h5800_0000);
    rd(8'h00, 32'h4000_0000);
    @(posedge clk);
    float_unit_irq <= 1'b1;
    cyc(5);
    #1 `CHK("fp route", 6'h01, core_irq)
    @(posedge clk);
    float_unit_irq <= 1'b0;
    wr(32'h4200_0000);
    `CHK("stall", 1'b1, exec_stall)
    @(posedge clk);
    irq_n <= 6'h3d;
    n = 0;
    while (exec_stall !== 1'b0 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("wake", 1'b0, exec_stall)
    @(posedge clk);
    irq_n <= 6'h3f;
    wr(32'h6080_0000);
    `CHK("alt caches", {5'h08, 5'h08}, {icache_kb, dcache_kb})
    `CHK("refill", 3'h4, refill_words)
    @(posedge clk);
    cache_data <= 32'h0000_0007;
    cache_tag <= 20'h00003;
    cyc(2);
    #1 `CHK("parity", 2'h2, {data_parity, tag_parity})
    $display("test software options done");
    wr(32'h8080_0000);
    wr(32'h0000_0000);
    `CHK("locked caches", {5'h08, 5'h08}, {icache_kb, dcache_kb})
    rd(8'h00, 32'h8080_0000);
    $display("test lock done");
    give_verdict();
  end
endmodule
